// >>> irv_consts.svh
// constants for the interrupt request vectoring block
`ifndef IRV_CONSTS_SVH
`define IRV_CONSTS_SVH
`define IRV_NSRC         8
`define IRV_VEC_BYTES    4
`define IRV_BRK_ADDR     32'h0fffffe7
`define IRV_ERASED       8'hff
`define IRV_SWI_LAST_ISP 8'h7f
`define IRV_PEND_RST     8'h00
`endif

// >>> irv_pkg.sv
// types for the interrupt request vectoring block
package irv_pkg;
	typedef struct packed {
		logic        valid;
		logic [7:0]  swiNum;
	} irv_swi_t;
	typedef enum logic [1:0] {
		IDLE,
		FETCH,
		JUMP
	} irv_state_t;
endpackage : irv_pkg

// >>> irv_vectoring.sv
// interrupt request flagging and vectoring
// Operation
// - each source owns a four-byte vector entry holding its handler address
// - on acceptance, control jumps to the address read from the vector
// - pending flag sets on a request and holds until acceptance or a software clear
// - pending flag clears automatically when the vector jump occurs
// - software writing 0 to a pending flag clears it
// - break with erased break byte jumps via software interrupt 0 vector
// - software interrupts 0..127 save stack select, select interrupt stack
// - software interrupts 128..255 leave stack selection unchanged
`timescale 1ns/1ps
`default_nettype none
`include "irv_consts.svh"
module irv_vectoring
(
	// clock and reset
	input  wire logic                      sys_clk,
	input  wire logic                      sys_rst,
	// peripheral requests and software flag clears
	input  wire logic [`IRV_NSRC-1:0]      reqPulse,
	input  wire logic [`IRV_NSRC-1:0]      swClrPendReq,
	// core side
	input  wire logic                      acceptReq,
	input  wire logic                      swiReq,
	input  wire logic [7:0]                swiNum,
	input  wire logic                      breakExec,
	input  wire logic [7:0]                brkByte,
	input  wire logic                      intReturn,
	input  wire logic                      stackSelIn,
	input  wire logic [31:0]               vecBase,
	// vector fetch port
	output logic                           vecRdReq_q,
	output logic [31:0]                    vecAddr_q,
	input  wire logic                      vecRdValid,
	input  wire logic [31:0]               vecRdData,
	// outputs to the core
	output logic [`IRV_NSRC-1:0]           pendingRequestFlag_q,
	output logic                           jumpValid_q,
	output logic [31:0]                    jumpAddr_q,
	output logic                           stackSel_q,
	output logic                           busy_q
);
	irv_pkg::irv_state_t state_q;
	logic [7:0] vecIdx_q;
	logic       isHw_q;
	logic       savedSel_q;
	logic       ispActive_q;
	logic [`IRV_NSRC-1:0] clrAccept;
	irv_pkg::irv_swi_t swi;

	function automatic logic [7:0] lowestPending(input logic [`IRV_NSRC-1:0] p);
		lowestPending = 8'h00;
		for (int i = `IRV_NSRC - 1; i >= 0; i--)
			if (p[i])
				lowestPending = 8'(i);
	endfunction : lowestPending

	function automatic logic [31:0] vecEntry(input logic [31:0] base,
		input logic [7:0] idx);
		vecEntry = base + 32'(idx) * 32'(`IRV_VEC_BYTES);
	endfunction : vecEntry

	always_comb
	begin
		swi.valid  = swiReq | (breakExec && brkByte == `IRV_ERASED);
		swi.swiNum = swiReq ? swiNum : 8'h00;
	end

	always_comb
	begin
		clrAccept = '0;
		if (state_q == irv_pkg::JUMP && isHw_q)
			clrAccept[vecIdx_q[2:0]] = 1'b1;
	end

	// set wins over both clears so a request is never lost
	always_ff @(posedge sys_clk or posedge sys_rst)
		if (sys_rst)
			pendingRequestFlag_q <= `IRV_PEND_RST;
		else
			pendingRequestFlag_q <= (pendingRequestFlag_q
				& ~clrAccept & ~swClrPendReq) | reqPulse;

	always_ff @(posedge sys_clk or posedge sys_rst)
		if (sys_rst)
		begin
			state_q    <= irv_pkg::IDLE;
			vecIdx_q   <= 8'h00;
			isHw_q     <= 1'b0;
			vecRdReq_q <= 1'b0;
			vecAddr_q  <= 32'h0;
			busy_q     <= 1'b0;
		end
		else
			unique case (state_q)
				irv_pkg::IDLE:
				begin
					if (swi.valid)
					begin
						vecIdx_q   <= swi.swiNum;
						isHw_q     <= 1'b0;
						vecRdReq_q <= 1'b1;
						vecAddr_q  <= vecEntry(vecBase, swi.swiNum);
						busy_q     <= 1'b1;
						state_q    <= irv_pkg::FETCH;
					end
					else if (acceptReq && |pendingRequestFlag_q)
					begin
						vecIdx_q   <= lowestPending(pendingRequestFlag_q);
						isHw_q     <= 1'b1;
						vecRdReq_q <= 1'b1;
						vecAddr_q  <= vecEntry(vecBase,
							lowestPending(pendingRequestFlag_q));
						busy_q     <= 1'b1;
						state_q    <= irv_pkg::FETCH;
					end
				end
				irv_pkg::FETCH:
					if (vecRdValid)
					begin
						vecRdReq_q <= 1'b0;
						state_q    <= irv_pkg::JUMP;
					end
				irv_pkg::JUMP:
				begin
					state_q <= irv_pkg::IDLE;
					busy_q  <= 1'b0;
				end
			endcase

	always_ff @(posedge sys_clk or posedge sys_rst)
		if (sys_rst)
		begin
			jumpValid_q <= 1'b0;
			jumpAddr_q  <= 32'h0;
		end
		else
		begin
			jumpValid_q <= state_q == irv_pkg::FETCH && vecRdValid;
			if (state_q == irv_pkg::FETCH && vecRdValid)
				jumpAddr_q <= vecRdData;
		end

	// stack select: 1 = user stack, 0 = interrupt stack pointer
	// one handler level is tracked; a nested entry overwrites the save
	always_ff @(posedge sys_clk or posedge sys_rst)
		if (sys_rst)
		begin
			stackSel_q  <= 1'b0;
			savedSel_q  <= 1'b0;
			ispActive_q <= 1'b0;
		end
		else if (state_q == irv_pkg::JUMP
			&& (isHw_q || vecIdx_q <= `IRV_SWI_LAST_ISP))
		begin
			savedSel_q  <= stackSelIn;
			stackSel_q  <= 1'b0;
			ispActive_q <= 1'b1;
		end
		else if (intReturn && ispActive_q)
		begin
			stackSel_q  <= savedSel_q;
			ispActive_q <= 1'b0;
		end
		// following the core here would drop the interrupt stack mid-handler
		else if (state_q == irv_pkg::IDLE && !ispActive_q)
			stackSel_q <= stackSelIn;

	sequence seqFetchDone;
		state_q == irv_pkg::FETCH && vecRdValid;
	endsequence : seqFetchDone

	sequence seqHwJumpSrc0;
		state_q == irv_pkg::JUMP && isHw_q && vecIdx_q == 8'h00
			&& !reqPulse[0];
	endsequence : seqHwJumpSrc0

	sequence seqIspEntry;
		state_q == irv_pkg::JUMP
			&& (isHw_q || vecIdx_q <= `IRV_SWI_LAST_ISP);
	endsequence : seqIspEntry

	chk_pend_holds: assert property (@(posedge sys_clk)
		disable iff (sys_rst) reqPulse[0] |=> pendingRequestFlag_q[0])
		else $error("pending flag did not set");
	chk_pend_keep: assert property (@(posedge sys_clk)
		disable iff (sys_rst) (pendingRequestFlag_q[0] && !swClrPendReq[0]
		&& state_q != irv_pkg::JUMP) |=> pendingRequestFlag_q[0])
		else $error("pending flag lost before acceptance");
	chk_accept_clear: assert property (@(posedge sys_clk)
		disable iff (sys_rst) seqHwJumpSrc0 |=> !pendingRequestFlag_q[0])
		else $error("flag not cleared at jump");
	chk_sw_clear: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		(swClrPendReq[1] && !reqPulse[1]) |=> !pendingRequestFlag_q[1])
		else $error("software clear ignored");
	chk_vec_addr: assert property (@(posedge sys_clk)
		disable iff (sys_rst) $rose(vecRdReq_q) |->
		vecAddr_q == $past(vecBase) + 32'(vecIdx_q) * 32'h4)
		else $error("vector address wrong");
	chk_fetch_hold: assert property (@(posedge sys_clk)
		disable iff (sys_rst) (vecRdReq_q && !vecRdValid) |=>
		vecRdReq_q && $stable(vecAddr_q))
		else $error("vector fetch dropped early");
	chk_jump_data: assert property (@(posedge sys_clk)
		disable iff (sys_rst) seqFetchDone |=>
		jumpValid_q && jumpAddr_q == $past(vecRdData))
		else $error("jump address not from vector");
	chk_jump_pulse: assert property (@(posedge sys_clk)
		disable iff (sys_rst) jumpValid_q |=> !jumpValid_q)
		else $error("jump strobe longer than one cycle");
	chk_busy_fetch: assert property (@(posedge sys_clk)
		disable iff (sys_rst) (vecRdReq_q || jumpValid_q) |-> busy_q)
		else $error("busy low during vector fetch");
	chk_brk_swi0: assert property (@(posedge sys_clk)
		disable iff (sys_rst) (state_q == irv_pkg::IDLE && breakExec
		&& !swiReq && brkByte == 8'hff) |=> vecIdx_q == 8'h00 && !isHw_q)
		else $error("break not redirected");
	chk_isp_sel: assert property (@(posedge sys_clk)
		disable iff (sys_rst) seqIspEntry |=> !stackSel_q && ispActive_q)
		else $error("interrupt stack not selected");
	chk_isp_hold: assert property (@(posedge sys_clk)
		disable iff (sys_rst) (ispActive_q && !intReturn) |=> !stackSel_q)
		else $error("interrupt stack left without return");
	chk_ret_restore: assert property (@(posedge sys_clk)
		disable iff (sys_rst) (intReturn && ispActive_q
		&& state_q != irv_pkg::JUMP) |=> stackSel_q == $past(savedSel_q))
		else $error("stack select not restored");
	chk_sp_keep: assert property (@(posedge sys_clk)
		disable iff (sys_rst) (state_q == irv_pkg::JUMP && !isHw_q
		&& vecIdx_q >= 8'h80 && !intReturn)
		|=> stackSel_q == $past(stackSel_q))
		else $error("stack select changed");
endmodule : irv_vectoring
`default_nettype wire

// >>> irv_vec_mem.sv
// vector memory model answering the block's handler fetches
`timescale 1ns/1ps
`default_nettype none
module irv_vec_mem
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	// fetch port
	input  wire logic        rdReq,
	input  wire logic [31:0] rdAddr,
	input  wire logic [1:0]  waitCycles,
	output logic             rdValid,
	output logic [31:0]      rdData
);
	logic [1:0] cnt;
	always @(posedge sys_clk)
		if (sys_rst)
		begin
			cnt     <= 2'h0;
			rdValid <= 1'b0;
			rdData  <= 32'h0;
		end
		else
		begin
			rdValid <= 1'b0;
			// data toggles between answers so a stale word never looks valid
			rdData <= ~rdData;
			if (rdReq && !rdValid)
			begin
				cnt <= cnt + 2'h1;
				if (cnt == waitCycles)
				begin
					cnt <= 2'h0;
					rdValid <= 1'b1;
					rdData <= rdAddr ^ 32'ha5a50000;
				end
			end
		end
endmodule : irv_vec_mem
`default_nettype wire

// >>> irv_vectoring_test.sv
// self-checking bench for the request vectoring block
`timescale 1ns/1ps
`default_nettype none
module irv_vectoring_test;
	logic        sys_clk, sys_rst, acc, swi, software_break_instruction, selIn, rdReq, rdVal, jv, sel;
	logic        ret, busy;
	logic [7:0]  req, clr, num, bb, pend;
	logic [31:0] base, addr, rdData, ja, lf;
	logic [1:0]  wt;
	logic [2:0]  s;
	logic [32:0] q[$];
	logic [32:0] e;
	int          nFail, totalChecks, k;
	irv_vectoring irv_vectoring_i (.sys_clk, .sys_rst, .reqPulse(req),
		.swClrPendReq(clr), .acceptReq(acc), .swiReq(swi), .swiNum(num),
		.breakExec(software_break_instruction), .brkByte(bb), .intReturn(ret), .stackSelIn(selIn),
		.vecBase(base), .vecRdReq_q(rdReq), .vecAddr_q(addr),
		.vecRdValid(rdVal), .vecRdData(rdData), .pendingRequestFlag_q(pend),
		.jumpValid_q(jv), .jumpAddr_q(ja), .stackSel_q(sel), .busy_q(busy));
	irv_vec_mem irv_vec_mem_i (.sys_clk, .sys_rst, .rdReq, .rdAddr(addr),
		.waitCycles(wt), .rdValid(rdVal), .rdData);
	task automatic chk(input string nm, input logic [32:0] seen, exp);
		totalChecks++;
		if (seen !== exp)
		begin
			nFail++;
			$display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic finalReport;
		$display("checks %0d mismatches %0d", totalChecks, nFail);
		if (nFail == 0 && totalChecks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : finalReport
	function automatic logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : nxt
	// caller raised the request at this negedge; note the expected jump
	task automatic run(input logic [31:0] ent, input logic sl);
		int i;
		q.push_back({sl, ent ^ 32'ha5a50000});
		@(negedge sys_clk);
		{acc, swi, software_break_instruction} = 3'b000;
		for (i = 0; i < 20 && q.size() != 0; i++)
			@(negedge sys_clk);
		if (q.size() != 0)
			nFail++;
		q.delete();
		repeat (3) @(negedge sys_clk);
		chk("hold", {32'h0, sel}, {32'h0, sl});
		ret = 1'b1;
		@(negedge sys_clk);
		ret = 1'b0;
		chk("restore", {32'h0, sel}, {32'h0, selIn});
		@(negedge sys_clk);
	endtask : run
	always @(negedge sys_clk)
		if (jv === 1'b1)
		begin
			e = (q.size() != 0) ? q.pop_front() : 33'h1ffffffff;
			chk("jump", {1'b0, ja}, {1'b0, e[31:0]});
			chk("busy", {32'h0, busy}, 33'h1);
			@(negedge sys_clk);
			chk("stack", {32'h0, sel}, {32'h0, e[32]});
		end
	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	initial
	begin
		#200000;
		nFail++;
		finalReport();
	end
	initial
	begin
		{req, clr, acc, swi, num, software_break_instruction, bb, wt, selIn, ret} = '0;
		sys_rst = 1'b1;
		base = 32'h1000;
		lf = 32'd84164;
		repeat (12) @(negedge sys_clk);
		sys_rst = 1'b0;
		chk("pend", {25'h0, pend}, 33'h0);
		for (k = 0; k < 8; k++)
		begin
			lf = nxt(lf);
			{s, wt, selIn} = {lf[4:0], 1'b1};
			base = {lf[31:8], 8'h00};
			req = 8'h01 << s;
			@(negedge sys_clk);
			req = 8'h00;
			repeat (3) @(negedge sys_clk);
			chk("pend", {25'h0, pend}, {25'h0, 8'h01 << s});
			if (k[0])
			begin
				clr = 8'h01 << s;
				@(negedge sys_clk);
				clr = 8'h00;
				@(negedge sys_clk);
			end
			else
			begin
				acc = 1'b1;
				run(base + {27'h0, s, 2'b00}, 1'b0);
			end
			chk("pend", {25'h0, pend}, 33'h0);
			num = {k[0], lf[13:7]};
			swi = 1'b1;
			run(base + {22'h0, num, 2'b00}, k[0]);
		end
		bb = 8'hff;
		software_break_instruction = 1'b1;
		run(base, 1'b0);
		bb = 8'h7f;
		software_break_instruction = 1'b1;
		@(negedge sys_clk);
		software_break_instruction = 1'b0;
		chk("brk", {32'h0, busy}, 33'h0);
		repeat (12) @(negedge sys_clk);
		finalReport();
	end
endmodule : irv_vectoring_test
`default_nettype wire
